/* File: crc16_consts.vh */
`ifndef CRC16_CONSTS_VH
`define CRC16_CONSTS_VH

// Register indices; the byte address on the bus is four times the index.
`define CRC_IDX_DATA_PLAIN     10'h000
`define CRC_IDX_DATA_REVERSED  10'h002
`define CRC_IDX_SEED_RESULT    10'h004
`define CRC_IDX_RESULT_REVERSE 10'h006

// Bus geometry.
`define CRC_ADDR_W             12
`define CRC_DATA_W             32
`define CRC_STRB_W             4

// Byte lanes of a 16-bit register.
`define CRC_LO_MSB             7
`define CRC_LO_LSB             0
`define CRC_HI_MSB             15
`define CRC_HI_LSB             8

// Reset values.
`define CRC_DATA_RESET         16'h0000
`define CRC_SEED_RESET         16'hffff
`define CRC_RDATA_RESET        32'h0000_0000

// Generator polynomial x^16 + x^12 + x^5 + 1 without the x^16 term.
`define CRC_POLY               16'h1021

`endif

/* File: crc_byte_engine.v */
`timescale 1ns/1ps
`include "crc16_consts.vh"

// Folds one byte into the signature in a single cycle of combinational logic.
// The byte's bit 0 enters first, which matches a serial register that shifts
// the least significant data bit in first while the signature stays MSB-first.
module crc_byte_engine (
    input  wire [15:0] crcIn,
    input  wire [7:0]  dataByte,
    output reg  [15:0] crcOut
);

    reg     feedback;
    integer i;

    always @* begin
        crcOut   = crcIn;
        feedback = 1'b0;
        for (i = 0; i < 8; i = i + 1) begin
            feedback = crcOut[15] ^ dataByte[i];
            crcOut   = {crcOut[14:0], 1'b0} ^ (feedback ? `CRC_POLY : 16'h0000);
        end
    end

endmodule // crc_byte_engine

/* File: crc16_apb.v */
//Contract
//RULE1: Every register takes word and byte accesses.
//RULE2: Low byte bits 7..0, high byte 15..8.
//RULE3: Plain data-in at index 0, folds into signature.
//RULE4: Reversed data-in write updates both result views.
//RULE5: Reversed data-in reads back plain data-in content.
//RULE6: Reversed data-in at index 2, resets zero.
//RULE7: Seed at index 4, mirror at 6, reset FFFF.
//RULE8: Seed write restarts calculation, reads back value.
//RULE9: Reversed port mirrors bits within each byte.
//RULE10: Word takes two cycles, low byte first.
//RULE11: Mirror register is signature with bits reversed.
//RULE12: Byte write folds one byte; reads see completed writes.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`include "crc16_consts.vh"

module crc16_apb (
    input  wire                     clock,
    input  wire                     nrst,
    input  wire                     psel,
    input  wire                     penable,
    input  wire                     pwrite,
    input  wire [`CRC_ADDR_W-1:0]   paddr,
    input  wire [`CRC_DATA_W-1:0]   pwdata,
    input  wire [`CRC_STRB_W-1:0]   pstrb,
    output wire [`CRC_DATA_W-1:0]   prdata,
    output wire                     pready,
    output wire                     pslverr
);

    // Swaps the bit order inside one byte when asked to.
    function [7:0] orientByte;
        input [7:0] value;
        input       mirror;
        integer     k;
        begin
            orientByte = value;
            if (mirror) begin
                for (k = 0; k < 8; k = k + 1) begin
                    orientByte[k] = value[7-k];
                end
            end
        end
    endfunction

    // Full 16-bit mirror of the signature.
    function [15:0] mirrorWord;
        input [15:0] value;
        integer      k;
        begin
            mirrorWord = value;
            for (k = 0; k < 16; k = k + 1) begin
                mirrorWord[k] = value[15-k];
            end
        end
    endfunction

    // Byte-lane merge used by every writable register.
    function [15:0] mergeLanes;
        input [15:0] oldValue;
        input [15:0] newValue;
        input        laneLo;
        input        laneHi;
        begin
            mergeLanes = oldValue;
            if (laneLo) begin
                mergeLanes[`CRC_LO_MSB:`CRC_LO_LSB] = newValue[`CRC_LO_MSB:`CRC_LO_LSB];
            end
            if (laneHi) begin
                mergeLanes[`CRC_HI_MSB:`CRC_HI_LSB] = newValue[`CRC_HI_MSB:`CRC_HI_LSB];
            end
        end
    endfunction

    // Matches an aligned word address against one register index.
    function regHit;
        input [9:0] index;
        input       isAligned;
        input [9:0] target;
        begin
            regHit = isAligned && (index == target);
        end
    endfunction

    // Fold sequencer states.
    localparam FOLD_IDLE = 1'b0;
    localparam FOLD_HIGH = 1'b1;

    // Registers.
    reg  [15:0]             dataInReg;
    reg  [15:0]             dataInNext;
    reg  [15:0]             crcReg;
    reg  [15:0]             crcNext;
    reg                     foldStateReg;
    reg                     foldStateNext;
    reg  [7:0]              pendingByteReg;
    reg  [7:0]              pendingByteNext;
    reg  [`CRC_DATA_W-1:0]  rdataReg;
    reg  [`CRC_DATA_W-1:0]  rdataNext;

    // Decode.
    wire [9:0]              wordIndex;
    wire                    aligned;
    wire                    hitPlain;
    wire                    hitReversed;
    wire                    hitSeed;
    wire                    hitMirror;
    wire                    hitAny;
    wire                    accessDone;
    wire                    laneLo;
    wire                    laneHi;
    wire                    writeData;
    wire                    writeSeed;
    wire                    captureRead;
    wire                    foldBusy;
    wire                    laneAny;
    wire                    writePlain;
    wire                    writeReversed;

    // Engine feed.
    wire [7:0]              firstByte;
    reg  [7:0]              feedByte;
    wire [15:0]             stepped;
    reg  [15:0]             readValue;

    assign wordIndex   = paddr[`CRC_ADDR_W-1:2];
    assign aligned     = (paddr[1:0] == 2'b00);
    assign hitPlain    = regHit(wordIndex, aligned, `CRC_IDX_DATA_PLAIN);     // see RULE3
    assign hitReversed = regHit(wordIndex, aligned, `CRC_IDX_DATA_REVERSED);  // see RULE6
    assign hitSeed     = regHit(wordIndex, aligned, `CRC_IDX_SEED_RESULT);    // see RULE7
    assign hitMirror   = regHit(wordIndex, aligned, `CRC_IDX_RESULT_REVERSE); // see RULE7
    assign hitAny      = hitPlain | hitReversed | hitSeed | hitMirror;

    assign foldBusy    = (foldStateReg == FOLD_HIGH);

    // The second byte of a word write holds the bus, so a following access
    // can never observe a half-folded signature.
    assign pready      = ~foldBusy; // see RULE12
    assign accessDone  = psel & penable & ~foldBusy;
    assign pslverr     = accessDone & ~hitAny;

    // Lane 0 carries bits 7..0 and lane 1 bits 15..8; upper lanes are ignored.
    assign laneLo      = pstrb[0]; // see RULE1
    assign laneHi      = pstrb[1]; // see RULE2

    assign laneAny       = laneLo | laneHi;
    assign writePlain    = accessDone & pwrite & hitPlain & laneAny;
    assign writeReversed = accessDone & pwrite & hitReversed & laneAny;
    assign writeData     = writePlain | writeReversed;
    assign writeSeed     = accessDone & pwrite & hitSeed & laneAny;

    // Read data is captured while the transfer is still in progress, from the
    // next-state values, so it is valid from the first access cycle.
    assign captureRead = psel & ~accessDone;

    // A lone high-lane write folds only the high byte.
    assign firstByte   = laneLo ? pwdata[`CRC_LO_MSB:`CRC_LO_LSB]
                                : pwdata[`CRC_HI_MSB:`CRC_HI_LSB]; // see RULE12

    // Byte that enters the engine in this cycle.
    always @* begin
        case (foldStateReg)
            FOLD_HIGH: begin
                feedByte = pendingByteReg; // see RULE10
            end
            FOLD_IDLE: begin
                feedByte = orientByte(firstByte, hitReversed); // see RULE9
            end
            default: begin
                feedByte = 8'h00;
            end
        endcase
    end

    crc_byte_engine engine (
        .crcIn    (crcReg),
        .dataByte (feedByte),
        .crcOut   (stepped)
    );

    // Sequencer: a full-word data-in write parks its high byte for one cycle.
    always @* begin
        foldStateNext   = foldStateReg;
        pendingByteNext = pendingByteReg;
        case (foldStateReg)
            FOLD_IDLE: begin
                if (writeData && laneLo && laneHi) begin
                    foldStateNext   = FOLD_HIGH; // see RULE10
                    pendingByteNext = orientByte(pwdata[`CRC_HI_MSB:`CRC_HI_LSB],
                                                 hitReversed); // see RULE9
                end
            end
            FOLD_HIGH: begin
                foldStateNext = FOLD_IDLE;
            end
            default: begin
                foldStateNext = FOLD_IDLE;
            end
        endcase
    end

    // Signature: one engine step per data byte, or a lane-wise seed load.
    always @* begin
        crcNext = crcReg;
        case (foldStateReg)
            FOLD_IDLE: begin
                if (writeData) begin
                    crcNext = stepped; // see RULE3 see RULE4
                end else if (writeSeed) begin
                    crcNext = mergeLanes(crcReg, pwdata[15:0], laneLo, laneHi); // see RULE8
                end
            end
            FOLD_HIGH: begin
                // Second cycle of a word: the high byte goes in now.
                crcNext = stepped; // see RULE10
            end
            default: begin
                crcNext = crcReg;
            end
        endcase
    end

    // Both data-in views share one storage word; the reversed port stores the
    // bytes as written, so either address reads back the same value.
    always @* begin
        dataInNext = dataInReg;
        if (writeData) begin
            dataInNext = mergeLanes(dataInReg, pwdata[15:0], laneLo, laneHi); // see RULE5
        end
    end

    // Read multiplexer over next-state values; the mirror view is never stored
    // separately, so it cannot drift from the signature.
    always @* begin
        readValue = 16'h0000;
        if (aligned) begin
            case (wordIndex)
                `CRC_IDX_DATA_PLAIN: begin
                    readValue = dataInNext;
                end
                `CRC_IDX_DATA_REVERSED: begin
                    readValue = dataInNext; // see RULE5
                end
                `CRC_IDX_SEED_RESULT: begin
                    readValue = crcNext; // see RULE8
                end
                `CRC_IDX_RESULT_REVERSE: begin
                    readValue = mirrorWord(crcNext); // see RULE11
                end
                default: begin
                    readValue = 16'h0000;
                end
            endcase
        end
    end

    always @* begin
        rdataNext = rdataReg;
        if (captureRead) begin
            rdataNext = {16'h0000, readValue};
        end
    end

    // One process per register keeps each reset value beside its flop.
    always @(posedge clock) begin
        if (!nrst) begin
            dataInReg <= `CRC_DATA_RESET; // see RULE6
        end else begin
            dataInReg <= dataInNext;
        end
    end

    always @(posedge clock) begin
        if (!nrst) begin
            crcReg <= `CRC_SEED_RESET; // see RULE7
        end else begin
            crcReg <= crcNext;
        end
    end

    always @(posedge clock) begin
        if (!nrst) begin
            foldStateReg <= FOLD_IDLE;
        end else begin
            foldStateReg <= foldStateNext;
        end
    end

    always @(posedge clock) begin
        if (!nrst) begin
            pendingByteReg <= 8'h00;
        end else begin
            pendingByteReg <= pendingByteNext;
        end
    end

    always @(posedge clock) begin
        if (!nrst) begin
            rdataReg <= `CRC_RDATA_RESET;
        end else begin
            rdataReg <= rdataNext;
        end
    end

    assign prdata = rdataReg;

endmodule // crc16_apb

/* File: crc16_props.sv */
`timescale 1ns/1ps
`include "crc16_consts.vh"
module crc16_props (
    input wire                   clock,
    input wire                   nrst,
    input wire                   psel,
    input wire                   penable,
    input wire                   pwrite,
    input wire [`CRC_ADDR_W-1:0] paddr,
    input wire [`CRC_DATA_W-1:0] pwdata,
    input wire [`CRC_STRB_W-1:0] pstrb,
    input wire [`CRC_DATA_W-1:0] prdata,
    input wire                   pready,
    input wire                   pslverr
);
    wire acc    = psel & penable & pready;
    wire mapped = (paddr[11:5] == 7'h00) && (paddr[2:0] == 3'h0);
    wire wrData = acc & pwrite & mapped & ~paddr[4];
    function [15:0] flip16(input [15:0] v);
        integer k;
        begin
            for (k = 0; k < 16; k = k + 1)
                flip16[k] = v[15-k];
        end
    endfunction
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence s_rdSetup(a);
        psel && !penable && !pwrite && paddr == a;
    endsequence
    sequence s_seedWr;
        acc && pwrite && paddr == 12'h010 && pstrb[1:0] == 2'b11;
    endsequence
    sequence s_resRd;
        acc && !pwrite && paddr == 12'h010;
    endsequence
    property p_seed;
        s_seedWr ##1 s_rdSetup(12'h010) ##1 penable |-> prdata[15:0] == $past(pwdata[15:0], 2);
    endproperty
    property p_mirror;
        s_resRd ##1 s_rdSetup(12'h018) ##1 penable |-> prdata[15:0] == flip16($past(prdata[15:0], 2));
    endproperty
    property p_wordWait; wrData && pstrb[1:0] == 2'b11 |=> !pready; endproperty
    property p_byteFast; wrData && ^pstrb[1:0] |=> pready; endproperty
    property p_waitOne; !pready |=> pready; endproperty
    property p_err; acc && !mapped |-> pslverr; endproperty
    property p_ok; acc && mapped |-> !pslverr; endproperty
    property p_hiZero; acc && !pwrite |-> prdata[31:16] == 16'h0000; endproperty
    a_seed: assert property (p_seed) else $error("seed readback wrong");
    a_mirror: assert property (p_mirror) else $error("mirror not reversed");
    a_wordWait: assert property (p_wordWait) else $error("word fold took one cycle");
    a_byteFast: assert property (p_byteFast) else $error("byte fold stalled");
    a_waitOne: assert property (p_waitOne) else $error("wait longer than one");
    a_err: assert property (p_err) else $error("unmapped not refused");
    a_ok: assert property (p_ok) else $error("mapped refused");
    a_hiZero: assert property (p_hiZero) else $error("upper read bits set");
endmodule // crc16_props
bind crc16_apb crc16_props i_props (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

/* File: apb_master.sv */
`timescale 1ns/1ps
module apb_master (
    input  wire        clock,
    input  wire        pready,
    input  wire        pslverr,
    input  wire [31:0] prdata,
    output reg         psel = 1'b0,
    output reg         penable = 1'b0,
    output reg         pwrite = 1'b0,
    output reg  [11:0] paddr = 12'h000,
    output reg  [31:0] pwdata = 32'h0000_0000,
    output reg  [3:0]  pstrb = 4'h0
);
    // The request is left standing so that the next call can follow back to back.
    task xfer(input w, input [11:0] a, input [31:0] d, input [3:0] s,
              output [31:0] rd, output e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
    endtask
    task idle;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
endmodule // apb_master

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
    reg         clock = 1'b0;
    reg         nrst = 1'b0;
    wire        psel, penable, pwrite, pready, pslverr;
    wire [11:0] paddr;
    wire [31:0] pwdata, prdata;
    wire [3:0]  pstrb;
    reg  [15:0] sig = 16'hffff;
    reg  [31:0] rdv;
    reg         errv;
    reg  [11:0] port;
    integer     err_count = 0, total_checks = 0, i;
    always #5 clock = ~clock;
    apb_master i_master (.clock(clock), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb));
    crc16_apb i_dut (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    // Serial reference: data bit 0 enters first, signature shifts out at bit 15.
    function [15:0] fold(input [15:0] c, input [7:0] b);
        integer k;
        begin
            fold = c;
            for (k = 0; k < 8; k = k + 1)
                fold = {fold[14:0], 1'b0} ^ ((fold[15] ^ b[k]) ? 16'h1021 : 16'h0000);
        end
    endfunction
    function [7:0] flip8(input [7:0] v);
        integer k;
        begin
            for (k = 0; k < 8; k = k + 1)
                flip8[k] = v[7-k];
        end
    endfunction
    task cmp(input [8*5-1:0] name, input [31:0] exp, input [31:0] got);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("Error %0s expected %h seen %h", name, exp, got);
        end
    endtask
    task wr(input [11:0] a, input [15:0] d, input [3:0] s);
        i_master.xfer(1'b1, a, {16'h0000, d}, s, rdv, errv);
        cmp("werr", {31'b0, a > 12'h018}, {31'b0, errv});
        if (a == 12'h010)
            sig = {s[1] ? d[15:8] : sig[15:8], s[0] ? d[7:0] : sig[7:0]};
        if (a == 12'h000 || a == 12'h008) begin
            if (s[0]) sig = fold(sig, a[3] ? flip8(d[7:0]) : d[7:0]);
            if (s[1]) sig = fold(sig, a[3] ? flip8(d[15:8]) : d[15:8]);
        end
    endtask
    task rd(input [11:0] a, input [31:0] exp);
        i_master.xfer(1'b0, a, 32'h0000_0000, 4'h0, rdv, errv);
        cmp("rdata", exp, rdv);
        cmp("rerr", {31'b0, a > 12'h018}, {31'b0, errv});
    endtask
    task end_of_test;
        $display("Checks %0d, errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        #100000;
        err_count = err_count + 1;
        end_of_test;
    end
    initial begin
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        rd(12'h000, 32'h0000_0000);
        rd(12'h008, 32'h0000_0000);
        rd(12'h010, 32'h0000_ffff);
        rd(12'h018, 32'h0000_ffff);
        for (i = 0; i < 2; i = i + 1) begin
            port = i ? 12'h008 : 12'h000;
            wr(12'h010, 16'hffff, 4'h3);
            rd(12'h010, 32'h0000_ffff);
            wr(port, 16'h3231, 4'h3);
            wr(port, 16'h3433, 4'h3);
            wr(port, 16'h3635, 4'h3);
            wr(port, 16'h3837, 4'h3);
            rd(port, 32'h0000_3837);
            wr(port, 16'h0039, 4'h1);
            rd(12'h010, {16'h0000, sig});
            rd(12'h010, i ? 32'h0000_29b1 : 32'h0000_89f6);
            rd(12'h018, {16'h0000, flip8(sig[7:0]), flip8(sig[15:8])});
        end
        wr(12'h000, 16'hab00, 4'h2);
        rd(12'h010, {16'h0000, sig});
        wr(12'h010, 16'h0012, 4'h1);
        wr(12'h010, 16'h3400, 4'h2);
        rd(12'h010, 32'h0000_3412);
        wr(12'h018, 16'h5555, 4'h3);
        rd(12'h018, {16'h0000, flip8(sig[7:0]), flip8(sig[15:8])});
        rd(12'h020, 32'h0000_0000);
        i_master.idle;
        end_of_test;
    end
endmodule // testbench
